/* File: bench/msb_link_assertions.sv */
module msb_checker #(
  parameter int unsigned INIT_CYCLES = 50
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Host-driven lines
  input wire logic module_select_n,
  input wire logic module_reset_n,
  input wire logic scl,
  // Module drivers and resolved wires
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic att_o,
  input wire logic att_oe,
  input wire logic attention_n,
  input wire logic module_present_n
);
  // Slack covers synchronisers and flag registers after init ends
  localparam int ATT_MAX = INIT_CYCLES + 40;
  logic [10:0] low_q, low_d;
  logic [3:0] high_q, high_d;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Length of the module reset pulse and time since it ended
  always_comb begin
    low_d = module_reset_n ? 11'h000 : low_q + {10'h000, low_q != 11'h7FF};
    high_d = !module_reset_n ? 4'h0 : high_q + {3'h0, high_q != 4'hF};
  end
  always_ff @(posedge aclk) begin
    low_q <= aresetn ? low_d : 11'h000;
    high_q <= aresetn ? high_d : 4'hF;
  end

  a_att_pull_only: assert property (!(att_oe && att_o))
    else $error("Attention line driven high");
  a_sda_pull_only: assert property (!(dev_sda_oe && dev_sda_o))
    else $error("Data line driven high by module");
  a_present_low: assert property ($past(aresetn) |-> !module_present_n)
    else $error("Present line not pulled low");
  a_quiet_unselected: assert property (module_select_n [*5] |-> !dev_sda_oe)
    else $error("Module drives data while not selected");
  a_drive_in_low: assert property ($rose(dev_sda_oe) |-> !scl)
    else $error("Module took data line while clock high");
  a_clock_quarter: assert property ($changed(scl) |=> $stable(scl) [*7])
    else $error("Serial clock phase too short");
  a_init_attention: assert property ($rose(aresetn) |-> ##[1:ATT_MAX] !attention_n)
    else $error("No completion attention after power-up");
  a_reset_attention: assert property (
    $rose(module_reset_n) && low_q >= 11'h3F2 |-> ##[1:ATT_MAX] !attention_n)
    else $error("No completion attention after module reset");
  a_att_held: assert property ($rose(attention_n) |-> !module_select_n || high_q < 4'h8)
    else $error("Attention released without serial access");
endmodule : msb_checker

/* File: bench/test_module_sideband_management.sv */
`include "msb_cfg.svh"

module test_module_sideband_management;
  timeunit 1ns;
  timeprecision 1ps;
  // Short init keeps the run brief
  localparam int unsigned INIT = 50;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, st;
  logic awready, wready, bvalid, arready, rvalid, tx_off, power_limited, los, ready;
  logic [1:0] bresp, rresp, rr;
  logic [3:0][7:0] rx_level = {4{8'h40}};
  int miscompares = 0, compares = 0;

  always #5 aclk = ~aclk;

  msb_link_if link();
  msb_host msb_host_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .link(link));
  msb_device #(.INIT_CYCLES(INIT)) msb_device_i (.aclk(aclk), .aresetn(aresetn), .link(link),
    .rx_level(rx_level), .tx_off(tx_off), .power_limited(power_limited),
    .receive_signal_loss_alarm(los), .ready(ready));
  msb_checker #(.INIT_CYCLES(INIT)) msb_checker_i (.aclk(aclk), .aresetn(aresetn),
    .module_select_n(link.module_select_n), .module_reset_n(link.module_reset_n),
    .scl(link.scl), .dev_sda_o(link.dev_sda_o), .dev_sda_oe(link.dev_sda_oe),
    .att_o(link.att_o), .att_oe(link.att_oe), .attention_n(link.attention_n),
    .module_present_n(link.module_present_n));

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_word

  task automatic check_bit(input logic got, input logic exp);
    check_word({31'h0, got}, {31'h0, exp});
  endtask : check_bit

  // A wait that ran out is a mismatch and ends the run
  task automatic hang();
    check_bit(1'b0, 1'b1);
    wrap_up();
  endtask : hang

  // Write with both channels offered together, bready held until the answer
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    logic got;
    got = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 50 && !got; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        got = 1'b1;
        bready <= 1'b0;
        check_word({30'h0, bresp}, {30'h0, er});
      end
    end
    if (!got) hang();
  endtask : axi_write

  task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic got;
    got = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 50 && !got; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        got = 1'b1;
        d = rdata;
        r = rresp;
        rready <= 1'b0;
      end
    end
    if (!got) hang();
  endtask : axi_read

  // Poll status until the serial frame has ended; a read takes two frames, about 1300 cycles
  task automatic wait_idle();
    st = 32'h100;
    for (int n = 0; n < 1000 && st[8] !== 1'b0; n++) axi_read(`MSB_AXI_STAT, st, rr);
    if (st[8] !== 1'b0) hang();
  endtask : wait_idle

  task automatic serial(input logic [31:0] cmd);
    axi_write(`MSB_AXI_CMD, cmd, `MSB_RESP_OK);
    wait_idle();
  endtask : serial

  task automatic mod_read(input logic [2:0] idx, input logic [7:0] ex);
    serial({15'h0, 1'b1, 5'h0, idx, 8'h00});
    check_word({23'h0, st[9], st[7:0]}, {24'h0, ex});
  endtask : mod_read

  task automatic mod_write(input logic [2:0] idx, input logic [7:0] d);
    serial({21'h0, idx, d});
    check_bit(st[9], 1'b0);
  endtask : mod_write

  // Line changes pass through host register and module synchronisers
  task automatic ctrl(input logic [3:0] v);
    axi_write(`MSB_AXI_CTRL, {28'h0, v}, `MSB_RESP_OK);
    repeat (6) @(posedge aclk);
  endtask : ctrl

  task automatic wait_ready();
    for (int n = 0; n < INIT + 60 && ready !== 1'b1; n++) @(posedge aclk);
    repeat (4) @(posedge aclk);
  endtask : wait_ready

  task automatic s_power_up();
    check_bit(ready, 1'b0);
    wait_ready();
    check_bit(ready, 1'b1);
    check_bit(link.attention_n, 1'b0);
    check_bit(link.module_present_n, 1'b0);
    axi_read(`MSB_AXI_STAT, st, rr);
    check_word({30'h0, st[11:10]}, 32'h3);
  endtask : s_power_up

  // Deselected read must not be answered nor clear flags
  task automatic s_select();
    ctrl(4'h0);
    serial(32'h10100);
    check_bit(st[9], 1'b1);
    check_bit(link.attention_n, 1'b0);
    ctrl(4'h1);
    mod_read(3'h1, 8'h10);
    check_bit(link.attention_n, 1'b1);
    mod_read(3'h0, 8'h00);
  endtask : s_select

  task automatic s_tx_low_power();
    for (int i = 0; i < 4; i++) begin
      ctrl({i[0], 3'h1});
      mod_write(3'h2, {7'h0, i[1]});
      check_bit(tx_off, i[0] | i[1]);
    end
    ctrl(4'h5);
    check_bit(power_limited, 1'b1);
    mod_read(3'h0, 8'h06);
    ctrl(4'h1);
    check_bit(power_limited, 1'b0);
  endtask : s_tx_low_power

  // Each lane just below, then at, the loss threshold
  task automatic s_loss();
    for (int k = 0; k < 4; k++) begin
      @(posedge aclk);
      rx_level[k] <= 8'h1F;
      repeat (4) @(posedge aclk);
      check_bit(los, 1'b1);
      check_bit(link.attention_n, 1'b0);
      mod_read(3'h3, 8'h01 << k);
      mod_read(3'h4 + k[2:0], 8'h1F);
      mod_read(3'h1, 8'h01 << k);
      check_bit(link.attention_n, 1'b1);
      rx_level[k] <= 8'h20;
      repeat (4) @(posedge aclk);
      check_bit(los, 1'b0);
    end
  endtask : s_loss

  task automatic s_module_reset();
    mod_write(3'h2, 8'h01);
    ctrl(4'h3);
    repeat (100) @(posedge aclk);
    ctrl(4'h1);
    check_bit(tx_off, 1'b1);
    ctrl(4'h3);
    repeat (1100) @(posedge aclk);
    ctrl(4'h1);
    wait_ready();
    check_bit(tx_off, 1'b0);
    check_bit(link.attention_n, 1'b0);
    mod_read(3'h1, 8'h10);
  endtask : s_module_reset

  // Unmapped places and a command while busy are refused
  task automatic s_refusals();
    axi_write(4'hC, 32'h0, `MSB_RESP_ERR);
    axi_read(4'hC, st, rr);
    check_word({rr, st[29:0]}, {`MSB_RESP_ERR, 30'h0});
    axi_write(`MSB_AXI_CMD, 32'h10000, `MSB_RESP_OK);
    axi_write(`MSB_AXI_CMD, 32'h10100, `MSB_RESP_ERR);
    wait_idle();
    check_word({23'h0, st[9], st[7:0]}, 32'h0);
  endtask : s_refusals

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    s_power_up();
    s_select();
    s_tx_low_power();
    s_loss();
    s_module_reset();
    s_refusals();
    wrap_up();
  end
endmodule : test_module_sideband_management

/* File: core/msb_cfg.svh */
`ifndef MSB_CFG_SVH
`define MSB_CFG_SVH

// Clock rate and timing
`define MSB_CLK_MHZ 100
`define MSB_INIT_TIME_MS 2000
`define MSB_INIT_CYC (`MSB_INIT_TIME_MS * `MSB_CLK_MHZ * 1000)
`define MSB_RST_MIN_NS 10000
`define MSB_RST_MIN_CYC ((`MSB_RST_MIN_NS * `MSB_CLK_MHZ + 999) / 1000)
`define MSB_SCL_QTR_CYC 8

// Two-wire bus address and memory map of the module
`define MSB_DEV_ADDR 7'h50
`define MSB_MAP_STATUS 3'h0
`define MSB_MAP_FLAGS 3'h1
`define MSB_MAP_CTRL 3'h2
`define MSB_MAP_LOS 3'h3
`define MSB_ST_NOT_READY 0
`define MSB_ST_TX_OFF 1
`define MSB_ST_LOW_POWER 2
`define MSB_FLAG_INIT 4
`define MSB_CTRL_TRANSMIT_DISABLE 0
`define MSB_CTRL_RST 1'h0
`define MSB_FLAGS_RST 5'h00
`define MSB_LOS_THRESH 8'h20
`define MSB_LANES 4

// Host AXI4-Lite map
`define MSB_AXI_CTRL 4'h0
`define MSB_AXI_CMD 4'h4
`define MSB_AXI_STAT 4'h8
`define MSB_HC_SEL 0
`define MSB_HC_RST 1
`define MSB_HC_LP 2
`define MSB_HC_TXD 3
`define MSB_CMD_READ 16
`define MSB_STAT_BUSY 8
`define MSB_STAT_NACK 9
`define MSB_STAT_ATT 10
`define MSB_STAT_PRES 11
`define MSB_RESP_OK 2'h0
`define MSB_RESP_ERR 2'h2

`endif

/* File: core/msb_device.sv */
`include "msb_cfg.svh"

// Operation
// [RULE1] Serve serial commands only while selected
// [RULE2] Host gives each module own select
// [RULE3] Long reset pulse restores all defaults
// [RULE4] Host ignores status until reset completes
// [RULE5] Reset end raises attention, clears not-ready
// [RULE6] Power-up raises same completion attention
// [RULE7] Attention low signals fault or status
// [RULE8] Host reads serial bus to find cause
// [RULE9] Attention is open-drain, pull low only
// [RULE10] Pin or serial disable turns transmitter off
// [RULE11] Any lane below threshold raises loss alarm
// [RULE12] Lane levels monitored, readable over serial
// [RULE13] Low-power input limits module power
// [RULE14] Module pulls present line to ground
// [RULE15] Memory map reached only over serial bus
// [RULE16] Fully functional within 2000 ms
// [RULE17] Short pulses ignored, not-ready held until done
// [RULE18] Attention held until flags read or cleared
module msb_device #(
  parameter int unsigned INIT_CYCLES = `MSB_INIT_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Sideband link
  msb_link_if.dev link,
  // Lane levels from the receivers
  input wire logic [`MSB_LANES-1:0][7:0] rx_level,
  // Module controls
  output logic tx_off,
  output logic power_limited,
  output logic receive_signal_loss_alarm,
  output logic ready
);

  localparam logic [9:0] RST_MIN = 10'(`MSB_RST_MIN_CYC);
  localparam logic [27:0] INIT_LAST = 28'(INIT_CYCLES - 1);

  msb_pkg::msb_dev_t q, d;
  logic scl, sda, sel, rise, fall, sta, sto, init_done;
  logic [7:0] rbyte;
  logic [4:0] rd_clr;
  logic [`MSB_LANES-1:0] los_now;

  // Synchronised link levels; edges come from second stage and its delay
  assign scl = q.scl_sy[1];
  assign sda = q.sda_sy[1];
  assign sel = !q.sel_sy[1];
  assign rise = scl && !q.scl_p;
  assign fall = !scl && q.scl_p;
  assign sta = scl && q.scl_p && q.sda_p && !sda;
  assign sto = scl && q.scl_p && !q.sda_p && sda;

  // Per-lane loss compare against the threshold
  genvar i;
  generate
    for (i = 0; i < `MSB_LANES; i++) begin : g_lane
      assign los_now[i] = rx_level[i] < `MSB_LOS_THRESH; // [RULE11]
    end
  endgenerate

  always_comb begin
    d = q;
    rbyte = 8'h00;
    rd_clr = 5'h00;
    init_done = 1'b0;

    // Two-stage synchronisers on every pin input
    d.scl_sy = {q.scl_sy[0], link.scl};
    d.sda_sy = {q.sda_sy[0], link.sda};
    d.sel_sy = {q.sel_sy[0], link.module_select_n};
    d.rst_sy = {q.rst_sy[0], link.module_reset_n};
    d.lp_sy = {q.lp_sy[0], link.low_power_select};
    d.txd_sy = {q.txd_sy[0], link.transmit_disable};
    d.scl_p = q.scl_sy[1];
    d.sda_p = q.sda_sy[1];

    // Memory map read mux, lane monitors from index 4 upward
    case (q.ptr)
      `MSB_MAP_STATUS: begin
        rbyte[`MSB_ST_NOT_READY] = q.dnr;
        rbyte[`MSB_ST_TX_OFF] = q.tx_off;
        rbyte[`MSB_ST_LOW_POWER] = q.lp;
      end
      `MSB_MAP_FLAGS: rbyte = {3'h0, q.flags};
      `MSB_MAP_CTRL: rbyte[`MSB_CTRL_TRANSMIT_DISABLE] = q.soft_txd;
      `MSB_MAP_LOS: rbyte = {4'h0, q.los};
      default: rbyte = q.mon[q.ptr[1:0]]; // [RULE12]
    endcase

    // Serial engine; deselect or stop drops back to idle at once
    if (sto || !sel) begin // [RULE1]
      d.st = msb_pkg::D_IDLE;
      d.sda_oe = 1'b0;
    end else if (sta) begin
      d.st = msb_pkg::D_ADDR;
      d.bitc = 4'h0;
      d.sda_oe = 1'b0;
    end else begin
      case (q.st)
        msb_pkg::D_ADDR, msb_pkg::D_REG, msb_pkg::D_WDAT: begin
          if (rise) begin
            d.sh = {q.sh[6:0], sda};
            d.bitc = q.bitc + 4'h1;
          end
          // Byte complete: acknowledge during the ninth clock
          if (fall && q.bitc == 4'h8) begin
            d.bitc = 4'h0;
            d.sda_oe = 1'b1;
            case (q.st)
              msb_pkg::D_ADDR: begin
                if (q.sh[7:1] == `MSB_DEV_ADDR) begin
                  d.rw = q.sh[0];
                  d.st = msb_pkg::D_AACK;
                end else begin
                  d.sda_oe = 1'b0;
                  d.st = msb_pkg::D_IDLE;
                end
              end
              msb_pkg::D_REG: begin
                d.ptr = q.sh[2:0];
                d.st = msb_pkg::D_RACK;
              end
              default: begin
                d.st = msb_pkg::D_WACK;
                if (q.ptr == `MSB_MAP_CTRL) begin
                  d.soft_txd = q.sh[`MSB_CTRL_TRANSMIT_DISABLE]; // [RULE15]
                end
                if (q.ptr == `MSB_MAP_FLAGS) begin
                  rd_clr = q.sh[4:0]; // [RULE18]
                end
              end
            endcase
          end
        end
        msb_pkg::D_AACK, msb_pkg::D_RACK, msb_pkg::D_WACK: begin
          if (fall) begin
            d.sda_oe = 1'b0;
            d.st = msb_pkg::D_WDAT;
            if (q.st == msb_pkg::D_WACK) begin
              d.ptr = q.ptr + 3'h1;
            end
            if (q.st == msb_pkg::D_AACK) begin
              d.st = q.rw ? msb_pkg::D_RDAT : msb_pkg::D_REG;
            end
            // Read: first data bit goes out on the same falling edge
            if (q.st == msb_pkg::D_AACK && q.rw) begin
              d.sh = {rbyte[6:0], 1'b0};
              d.sda_oe = !rbyte[7];
              d.bitc = 4'h1;
              if (q.ptr == `MSB_MAP_FLAGS) begin
                rd_clr = q.flags; // [RULE18]
              end
            end
          end
        end
        msb_pkg::D_RDAT: begin
          if (fall) begin
            if (q.bitc == 4'h8) begin
              d.sda_oe = 1'b0;
              d.bitc = 4'h0;
              d.st = msb_pkg::D_MACK;
            end else begin
              d.sda_oe = !q.sh[7];
              d.sh = {q.sh[6:0], 1'b0};
              d.bitc = q.bitc + 4'h1;
            end
          end
        end
        msb_pkg::D_MACK: begin
          // Host acknowledge continues with the next byte, no-ack ends
          if (rise) begin
            if (sda) begin
              d.st = msb_pkg::D_IDLE;
            end else begin
              d.ptr = q.ptr + 3'h1;
              d.st = msb_pkg::D_AACK;
            end
          end
        end
        default: ;
      endcase
    end

    // Reset pulse length filter; saturates at the minimum
    if (q.rst_sy[1]) begin
      d.rst_cnt = 10'h000;
    end else if (q.rst_cnt != RST_MIN) begin
      d.rst_cnt = q.rst_cnt + 10'h001; // [RULE17]
    end

    // Initialisation timer, runs after power-up and after each reset held to the minimum
    if (q.dnr) begin
      if (q.init_cnt == INIT_LAST) begin
        d.dnr = 1'b0; // [RULE5] [RULE16]
        init_done = 1'b1; // [RULE6]
      end else begin
        d.init_cnt = q.init_cnt + 28'h0000001;
      end
    end

    // Sticky flags; a new event wins over a clear in the same cycle
    d.flags = (q.flags & ~rd_clr) | {init_done, los_now & ~q.los}; // [RULE18]
    d.los = los_now;
    d.mon = rx_level; // [RULE12]

    // Reset held past the minimum returns every setting to default
    if (q.rst_cnt == RST_MIN) begin // [RULE3]
      d.soft_txd = `MSB_CTRL_RST;
      d.flags = `MSB_FLAGS_RST;
      d.dnr = 1'b1; // [RULE17]
      d.init_cnt = 28'h0000000;
      d.st = msb_pkg::D_IDLE;
      d.sda_oe = 1'b0;
      d.ptr = 3'h0;
    end

    // Pin outputs, all registered
    d.tx_off = q.txd_sy[1] || d.soft_txd; // [RULE10]
    d.lp = q.lp_sy[1]; // [RULE13]
    d.los_out = |los_now; // [RULE11]
    d.att_oe = |q.flags; // [RULE7] [RULE9]
    d.prs_oe = 1'b1; // [RULE14]
    d.rdy = !d.dnr; // [RULE16]
  end

  // State register; idle lines read high after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.scl_sy <= 2'h3;
      q.sda_sy <= 2'h3;
      q.sel_sy <= 2'h3;
      q.rst_sy <= 2'h3;
      q.scl_p <= 1'b1;
      q.sda_p <= 1'b1;
      q.dnr <= 1'b1; // [RULE6]
    end else begin
      q <= d;
    end
  end

  // Open-drain drivers only ever pull low
  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe = q.sda_oe;
  assign link.att_o = 1'b0; // [RULE9]
  assign link.att_oe = q.att_oe;
  assign link.prs_o = 1'b0;
  assign link.prs_oe = q.prs_oe;
  assign tx_off = q.tx_off;
  assign power_limited = q.lp;
  assign receive_signal_loss_alarm = q.los_out;
  assign ready = q.rdy;

endmodule : msb_device

/* File: core/msb_host.sv */
`include "msb_cfg.svh"

module msb_host (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [3:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Sideband link
  msb_link_if.host link
);

  msb_pkg::msb_host_t q, d;
  logic tick, rx, last, sda;
  logic [7:0] cur;

  assign sda = q.sda_sy[1];
  assign tick = q.div == 3'(`MSB_SCL_QTR_CYC - 1);
  assign rx = q.ph2 && q.bi == 2'h1;
  assign last = q.rd ? q.bi == 2'h1 : q.bi == 2'h2;

  always_comb begin
    d = q;
    d.sda_sy = {q.sda_sy[0], link.sda};
    d.att_sy = {q.att_sy[0], link.attention_n};
    d.prs_sy = {q.prs_sy[0], link.module_present_n};
    d.div = tick ? 3'h0 : q.div + 3'h1;
    case (q.bi)
      2'h0: cur = {`MSB_DEV_ADDR, q.ph2};
      2'h1: cur = {5'h00, q.ptr};
      default: cur = q.wdat;
    endcase

    // Bit sequencer, four quarter periods per clock of the link
    if (tick) begin
      d.qt = q.qt + 2'h1;
      case (q.st)
        msb_pkg::H_STA: begin
          d.scl = 1'b1;
          if (q.qt == 2'h1) d.sda_oe = 1'b1;
          if (q.qt == 2'h3) begin
            d.st = msb_pkg::H_BIT;
            d.bitn = 4'h0;
          end
        end
        msb_pkg::H_BIT: begin
          if (q.qt == 2'h0) begin
            d.scl = 1'b0;
            d.sda_oe = (q.bitn != 4'h8 && !rx) ? !cur[3'(4'h7 - q.bitn)] : 1'b0;
          end
          if (q.qt == 2'h1) d.scl = 1'b1;
          // Sample late in the high phase, after the synchroniser delay
          if (q.qt == 2'h3) begin
            d.bitn = q.bitn + 4'h1;
            if (q.bitn != 4'h8) begin
              if (rx) d.sh = {q.sh[6:0], sda};
            end else begin
              d.bitn = 4'h0;
              if (!rx && sda) begin
                d.nack = 1'b1;
                d.st = msb_pkg::H_STO;
              end else if (last) begin
                d.st = msb_pkg::H_STO;
              end else begin
                d.bi = q.bi + 2'h1;
              end
            end
          end
        end
        msb_pkg::H_STO: begin
          if (q.qt == 2'h0) begin
            d.scl = 1'b0;
            d.sda_oe = 1'b1;
          end
          if (q.qt == 2'h1) d.scl = 1'b1;
          if (q.qt == 2'h2) d.sda_oe = 1'b0;
          // A read sets the pointer first, then fetches in a second frame
          if (q.qt == 2'h3) begin
            d.bi = 2'h0;
            if (q.rd && !q.ph2 && !q.nack) begin
              d.ph2 = 1'b1;
              d.st = msb_pkg::H_STA;
            end else begin
              d.busy = 1'b0;
              d.rdat = q.rd ? q.sh : q.rdat;
              d.st = msb_pkg::H_IDLE;
            end
          end
        end
        default: ;
      endcase
    end

    // Write channel: address and data taken in either order
    if (awvalid && q.awready) begin
      d.awaddr = awaddr;
      d.awready = 1'b0;
    end
    if (wvalid && q.wready) begin
      d.wdata = wdata;
      d.wready = 1'b0;
    end
    if (!q.awready && !q.wready && !q.bvalid) begin
      d.bvalid = 1'b1;
      d.bresp = `MSB_RESP_OK;
      case (q.awaddr)
        `MSB_AXI_CTRL: begin
          d.sel_n = !q.wdata[`MSB_HC_SEL];
          d.rst_n = !q.wdata[`MSB_HC_RST];
          d.lp = q.wdata[`MSB_HC_LP];
          d.txd = q.wdata[`MSB_HC_TXD];
        end
        `MSB_AXI_CMD: begin
          // A command while a frame runs is refused
          if (q.busy) begin
            d.bresp = `MSB_RESP_ERR;
          end else begin
            d.wdat = q.wdata[7:0];
            d.ptr = q.wdata[10:8];
            d.rd = q.wdata[`MSB_CMD_READ];
            d.busy = 1'b1;
            d.nack = 1'b0;
            d.ph2 = 1'b0;
            d.bi = 2'h0;
            d.qt = 2'h0;
            d.div = 3'h0;
            d.st = msb_pkg::H_STA;
          end
        end
        default: d.bresp = `MSB_RESP_ERR;
      endcase
    end
    if (q.bvalid && bready) begin
      d.bvalid = 1'b0;
      d.awready = 1'b1;
      d.wready = 1'b1;
    end

    // Read channel, one cycle to answer
    if (arvalid && q.arready) begin
      d.arready = 1'b0;
      d.rvalid = 1'b1;
      d.rresp = `MSB_RESP_OK;
      d.rdata = 32'h00000000;
      case (araddr)
        `MSB_AXI_CTRL: begin
          d.rdata[`MSB_HC_SEL] = !q.sel_n;
          d.rdata[`MSB_HC_RST] = !q.rst_n;
          d.rdata[`MSB_HC_LP] = q.lp;
          d.rdata[`MSB_HC_TXD] = q.txd;
        end
        `MSB_AXI_CMD: d.rdata = {15'h0000, q.rd, 5'h00, q.ptr, q.wdat};
        `MSB_AXI_STAT: begin
          d.rdata[7:0] = q.rdat;
          d.rdata[`MSB_STAT_BUSY] = q.busy;
          d.rdata[`MSB_STAT_NACK] = q.nack;
          d.rdata[`MSB_STAT_ATT] = !q.att_sy[1];
          d.rdata[`MSB_STAT_PRES] = !q.prs_sy[1];
        end
        default: d.rresp = `MSB_RESP_ERR;
      endcase
    end
    if (q.rvalid && rready) begin
      d.rvalid = 1'b0;
      d.arready = 1'b1;
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.sda_sy <= 2'h3;
      q.att_sy <= 2'h3;
      q.prs_sy <= 2'h3;
      q.sel_n <= 1'b1;
      q.rst_n <= 1'b1;
      q.scl <= 1'b1;
      q.awready <= 1'b1;
      q.wready <= 1'b1;
      q.arready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign link.module_select_n = q.sel_n; // [RULE2]
  assign link.module_reset_n = q.rst_n;
  assign link.low_power_select = q.lp;
  assign link.transmit_disable = q.txd;
  assign link.scl = q.scl;
  assign link.host_sda_o = 1'b0;
  assign link.host_sda_oe = q.sda_oe;
  assign awready = q.awready;
  assign wready = q.wready;
  assign bresp = q.bresp;
  assign bvalid = q.bvalid;
  assign arready = q.arready;
  assign rdata = q.rdata;
  assign rresp = q.rresp;
  assign rvalid = q.rvalid;

endmodule : msb_host

/* File: core/msb_link_if.sv */
interface msb_link_if;
  // Lines driven by the host
  logic module_select_n, module_reset_n, low_power_select, transmit_disable, scl;
  // Open-drain drivers of both ends
  logic host_sda_o, host_sda_oe, dev_sda_o, dev_sda_oe;
  logic att_o, att_oe, prs_o, prs_oe;
  // Wire levels, pull-ups give the high level
  logic sda, attention_n, module_present_n;

  assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));
  assign attention_n = !(att_oe && !att_o);
  assign module_present_n = !(prs_oe && !prs_o);

  modport dev (
    input module_select_n, module_reset_n, low_power_select, transmit_disable, scl, sda,
    output dev_sda_o, dev_sda_oe, att_o, att_oe, prs_o, prs_oe
  );
  modport host (
    output module_select_n, module_reset_n, low_power_select, transmit_disable, scl,
    output host_sda_o, host_sda_oe,
    input sda, attention_n, module_present_n
  );
endinterface : msb_link_if

/* File: core/msb_pkg.sv */
`include "msb_cfg.svh"

package msb_pkg;

  // Module end serial engine states
  typedef enum logic [3:0] {
    D_IDLE = 4'h0, D_ADDR = 4'h1, D_AACK = 4'h2, D_REG = 4'h3, D_RACK = 4'h4,
    D_WDAT = 4'h5, D_WACK = 4'h6, D_RDAT = 4'h7, D_MACK = 4'h8
  } msb_dev_st_t;

  // Host end sequencer states
  typedef enum logic [1:0] {
    H_IDLE = 2'h0, H_STA = 2'h1, H_BIT = 2'h2, H_STO = 2'h3
  } msb_host_st_t;

  // Whole state of the module end
  typedef struct packed {
    logic [1:0] scl_sy, sda_sy, sel_sy, rst_sy, lp_sy, txd_sy;
    logic scl_p, sda_p;
    msb_dev_st_t st;
    logic [3:0] bitc;
    logic [7:0] sh;
    logic [2:0] ptr;
    logic rw, sda_oe;
    logic [9:0] rst_cnt;
    logic [27:0] init_cnt;
    logic dnr, rdy;
    logic [4:0] flags;
    logic soft_txd;
    logic [`MSB_LANES-1:0] los;
    logic [`MSB_LANES-1:0][7:0] mon;
    logic att_oe, prs_oe, tx_off, lp, los_out;
  } msb_dev_t;

  // Whole state of the host end
  typedef struct packed {
    logic [1:0] sda_sy, att_sy, prs_sy;
    logic sel_n, rst_n, lp, txd;
    msb_host_st_t st;
    logic [2:0] div;
    logic [1:0] qt;
    logic [3:0] bitn;
    logic [1:0] bi;
    logic ph2, rd, busy, nack, scl, sda_oe;
    logic [2:0] ptr;
    logic [7:0] wdat, sh, rdat;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [3:0] awaddr;
    logic [31:0] wdata, rdata;
  } msb_host_t;

endpackage : msb_pkg
